// ### hw/sockbuf_pkg.sv
// Shared constants for the socket buffer register bank and its serial port.
// Assumes a 200 MHz system clock; all counts derive from that rate.
package sockbuf_pkg;
   localparam int          CLK_MHZ            = 200;
   localparam int          NUM_SOCKETS        = 8;
   localparam int          TX_BLOCKS          = 16;
   localparam int          BLOCK_BYTES        = 1024;
   // Register byte offsets within a socket window
   localparam logic [7:0]  OFS_TX_FREE        = 8'h20;
   localparam logic [7:0]  OFS_TX_CONSUME     = 8'h22;
   localparam logic [7:0]  OFS_TX_PRODUCE     = 8'h24;
   localparam logic [7:0]  OFS_RX_SIZE        = 8'h26;
   localparam logic [7:0]  OFS_RX_CONSUME     = 8'h28;
   localparam logic [7:0]  OFS_RX_PRODUCE     = 8'h2a;
   localparam logic [7:0]  OFS_EVENT_MASK     = 8'h2c;
   localparam logic [7:0]  OFS_IP_FRAGMENT    = 8'h2d;
   localparam logic [7:0]  OFS_KEEPALIVE      = 8'h2f;
   localparam logic [7:0]  OFS_TX_KBYTES      = 8'h1f;
   // Reset values, transmit size limit and established state code
   localparam logic [7:0]  EVENT_MASK_RESET   = 8'hff;
   localparam logic [4:0]  EVENT_MASK_BITS    = 5'h1f;
   localparam logic [15:0] IP_FRAGMENT_RESET  = 16'h4000;
   localparam logic [7:0]  KEEPALIVE_RESET    = 8'h00;
   localparam logic [4:0]  TX_KBYTES_RESET    = 5'h02;
   localparam logic [4:0]  TX_KBYTES_MAX      = 5'h10;
   localparam logic [7:0]  STATE_ESTABLISHED  = 8'h17;
   // Event flag bit positions
   localparam int          EV_CONNECT         = 0;
   localparam int          EV_DISCONNECT      = 1;
   localparam int          EV_RECEIVE         = 2;
   localparam int          EV_TIMEOUT         = 3;
   localparam int          EV_SEND_DONE       = 4;
   // Control word: bit 2 write, bits 7:5 socket number
   localparam int          CTL_WRITE_BIT      = 2;
   localparam int          CTL_SOCK_LSB       = 5;
   // Timing
   localparam int          RESET_STRETCH_MS   = 10;
   localparam int          RESET_STRETCH_CYC  = RESET_STRETCH_MS * CLK_MHZ * 1000;
   localparam int          KEEPALIVE_UNIT_S   = 5;
   localparam longint      KEEPALIVE_UNIT_CYC = longint'(KEEPALIVE_UNIT_S) * CLK_MHZ * 1000000;
   localparam int          KEEPALIVE_RETRIES  = 8;
endpackage

// ### hw/sock_bus_if.sv
// Carries received bytes and frame start/active flags from the serial front end to the bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface sock_bus_if;
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       frame_start;
   logic       frame_active;
   modport front (output byte_valid, output byte_data, output frame_start, output frame_active);
   modport bank  (input byte_valid, input byte_data, input frame_start, input frame_active);
endinterface

// ### hw/spi_byte_rx.sv
// Serial front end: samples link pins with the system clock, assembles bytes.
// Assumes the link clock is much slower than the system clock.
`timescale 1ns/1ps
module spi_byte_rx
   import sockbuf_pkg::*;
(
   input  wire logic    clk_in,
   input  wire logic    rst_n_in,
   input  wire logic    sclk_pin_in,
   input  wire logic    chip_select_n_in,
   input  wire logic    serial_in,
   input  wire logic    [7:0] tx_byte_in,
   output logic         shift_fall_out,
   output logic         tx_bit_out,
   sock_bus_if.front    bus
);
   logic [2:0] sclk_sync_reg;
   logic [2:0] cs_sync_reg;
   logic [2:0] sdi_sync_reg;
   logic       sclk_reg;
   logic       cs_n_reg;
   logic [2:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] tx_shift_reg;

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         sclk_sync_reg <= 3'h0;
         cs_sync_reg   <= 3'h7;
         sdi_sync_reg  <= 3'h0;
      end
      else
      begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin_in};
         cs_sync_reg   <= {cs_sync_reg[1:0], chip_select_n_in};
         sdi_sync_reg  <= {sdi_sync_reg[1:0], serial_in};
      end
   end

   // A level counts once stages two and three agree
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         sclk_reg <= 1'b0;
         cs_n_reg <= 1'b1;
      end
      else
      begin
         if (sclk_sync_reg[1] == sclk_sync_reg[2])
            sclk_reg <= sclk_sync_reg[2];
         if (cs_sync_reg[1] == cs_sync_reg[2])
            cs_n_reg <= cs_sync_reg[2];
      end
   end

   wire rise = !sclk_reg && (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2];
   wire fall = sclk_reg && (sclk_sync_reg[1] == sclk_sync_reg[2]) && !sclk_sync_reg[2];

   // Sample on rising edges, MSB first, eight bits a byte
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in || cs_n_reg)
      begin
         bit_cnt_reg     <= 3'h0;
         shift_reg       <= 7'h00;
         bus.byte_valid  <= 1'b0;
         bus.byte_data   <= 8'h00;
      end
      else
      begin
         bus.byte_valid <= 1'b0;
         if (rise && !cs_n_reg) // see R18
         begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= {shift_reg[5:0], sdi_sync_reg[2]};
            if (bit_cnt_reg == 3'h7)
            begin
               bus.byte_valid <= 1'b1;
               bus.byte_data  <= {shift_reg, sdi_sync_reg[2]};
            end
         end
      end
   end

   // Output shifts on falling edges; each byte loads on the falling edge while the bit count is zero so bit 7 is ready
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         tx_shift_reg   <= 8'h00;
         tx_bit_out     <= 1'b0;
         shift_fall_out <= 1'b0;
      end
      else
      begin
         shift_fall_out <= fall;
         if (fall && !cs_n_reg) // see R18
         begin
            if (bit_cnt_reg == 3'h0)
            begin
               tx_bit_out   <= tx_byte_in[7];
               tx_shift_reg <= {tx_byte_in[6:0], 1'b0};
            end
            else
            begin
               tx_bit_out   <= tx_shift_reg[7];
               tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         bus.frame_active <= 1'b0;
         bus.frame_start  <= 1'b0;
      end
      else
      begin
         bus.frame_active <= !cs_n_reg;
         bus.frame_start  <= !cs_n_reg && !bus.frame_active; // see R21
      end
   end
endmodule // spi_byte_rx

// ### hw/sock_regs.sv
// Socket buffer register bank behind a serial slave port, eight sockets.
// Assumes the protocol engine drives the event, send and receive strobes.
`timescale 1ns/1ps
// Summary of operation
// R1 - Transmit memory is 16 blocks of 1 KB, allocated to sockets 0..7 in order.
// R2 - Host keeps total transmit allocation within 16 KB.
// R3 - Free space equals full buffer size when nothing pending.
// R4 - Host never writes more bytes than reported free space.
// R5 - Consume pointer starts at buffer base after socket init; device advances it.
// R6 - Send command transmits bytes from consume to produce pointer.
// R7 - Host reads produce pointer, writes data, writes back advanced pointer.
// R8 - Received size register shows bytes waiting in receive buffer.
// R9 - Host reads receive consume pointer, reads data, writes it back advanced.
// R10 - Receive produce pointer starts at base, advances on received data.
// R11 - Event mask resets to ff; bits 4..0 gate flags; 7..5 read-only.
// R12 - Interrupt pin low only when mask bit and global socket bit set.
// R13 - Fragment field resets to 4000 and feeds the IP header.
// R14 - Keep-alive interval counts 5 s units; zero disables.
// R15 - Connected idle TCP socket sends keep-alive at the interval.
// R16 - Unacknowledged keep-alives beyond retry limit raise timeout event.
// R17 - Manual keep-alive only works when interval is zero.
// R18 - Mode 0 or 3, sample rising, shift falling, 8 bits MSB first.
// R19 - Host waits about 0.7 us before re-accessing a written register.
// R20 - Host leaves 50 ns between bytes, 100 ns after the control word.
// R21 - Frame: two address bytes, one control word, then data.
// R22 - Data bytes continue until chip select deasserts.
// R23 - Reset held while low and stretched about 10 ms after release.
// R24 - Event flags set by send done, timeout, receive, disconnect, connect.
// R25 - Transmit size accepts 0..16 KB, reset 2.
// R26 - Multi-byte registers big-endian; data bytes step through offsets.
// R27 - Control word holds write bit 2 and socket number bits 7..5.
module sock_regs
   import sockbuf_pkg::*;
#(
   parameter int RESET_CYCLES = RESET_STRETCH_CYC,
   parameter longint KA_UNIT_CYCLES = KEEPALIVE_UNIT_CYC
)
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ext_reset_n_in,
   input  wire logic        sclk_in,
   input  wire logic        chip_select_n_in,
   input  wire logic        serial_in,
   input  wire logic [7:0]  socket_irq_mask_global_in,
   input  wire logic [7:0]  socket_init_in,
   input  wire logic [7:0]  send_cmd_in,
   input  wire logic [7:0]  keepalive_cmd_in,
   input  wire logic [7:0]  keepalive_ack_in,
   input  wire logic [7:0]  tcp_mode_in,
   input  wire logic [63:0] socket_state_in,
   input  wire logic [7:0]  rx_load_in,
   input  wire logic [15:0] rx_load_len_in,
   input  wire logic [39:0] event_in,
   output logic             serial_out,
   output logic             serial_out_oe_n_out,
   output logic             irq_out_n,
   output logic [7:0]       keepalive_send_out,
   output logic [7:0]       tx_send_out,
   output logic [15:0]      tx_send_len_out,
   output logic [127:0]     ip_fragment_out,
   output logic             device_ready_out
);
   typedef enum {ST_ADDR_HI, ST_ADDR_LO, ST_CTRL, ST_DATA} frame_t;

   sock_bus_if bus ();
   frame_t      fstate_reg;
   logic [15:0] addr_reg;
   logic [7:0]  ctrl_reg;
   logic [2:0]  ext_sync_reg;
   logic        ext_ok_reg;
   logic [31:0] stretch_reg;
   logic        live_n;
   logic [7:0]  rd_byte;
   logic        tx_bit;
   logic        fall_pulse;

   logic [4:0]  tx_kbytes_reg   [NUM_SOCKETS];
   logic [15:0] tx_consume_reg  [NUM_SOCKETS];
   logic [15:0] tx_produce_reg  [NUM_SOCKETS];
   logic [15:0] rx_consume_reg  [NUM_SOCKETS];
   logic [15:0] rx_produce_reg  [NUM_SOCKETS];
   logic [4:0]  event_mask_reg  [NUM_SOCKETS];
   logic [4:0]  event_flags_reg [NUM_SOCKETS];
   logic [15:0] ip_frag_reg     [NUM_SOCKETS];
   logic [7:0]  keepalive_reg   [NUM_SOCKETS];
   logic [39:0] ka_timer_reg    [NUM_SOCKETS];
   logic [3:0]  ka_miss_reg     [NUM_SOCKETS];
   logic [15:0] tx_base         [NUM_SOCKETS];
   logic [15:0] tx_size         [NUM_SOCKETS];

   spi_byte_rx u_rx (
      .clk_in           (clk_in),
      .rst_n_in         (!live_n),
      .sclk_pin_in      (sclk_in),
      .chip_select_n_in (chip_select_n_in),
      .serial_in        (serial_in),
      .tx_byte_in       (rd_byte),
      .shift_fall_out   (fall_pulse),
      .tx_bit_out       (tx_bit),
      .bus              (bus)
   );

   // Reset stretch after the external pin rises
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         ext_sync_reg <= 3'h0;
         ext_ok_reg   <= 1'b0;
         stretch_reg  <= 32'h0;
      end
      else
      begin
         ext_sync_reg <= {ext_sync_reg[1:0], ext_reset_n_in};
         if (ext_sync_reg[1] == ext_sync_reg[2])
            ext_ok_reg <= ext_sync_reg[2];
         if (!ext_ok_reg)
            stretch_reg <= 32'h0; // see R23
         else if (stretch_reg != 32'(RESET_CYCLES))
            stretch_reg <= stretch_reg + 32'h1;
      end
   end
   assign live_n = !rst_n_in || (stretch_reg != 32'(RESET_CYCLES));

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         device_ready_out <= 1'b0;
      else
         device_ready_out <= !live_n;
   end

   // Block allocation in ascending socket order
   always_comb
   begin
      logic [15:0] acc;
      acc = 16'h0;
      for (int s = 0; s < NUM_SOCKETS; s++)
      begin
         tx_base[s] = acc; // see R1
         tx_size[s] = 16'(tx_kbytes_reg[s]) * 16'(BLOCK_BYTES);
         acc = acc + tx_size[s];
      end
   end

   // Frame sequencing
   always_ff @(posedge clk_in)
   begin
      if (live_n || bus.frame_start)
      begin
         fstate_reg <= ST_ADDR_HI;
         addr_reg   <= 16'h0;
         ctrl_reg   <= 8'h00;
      end
      else if (bus.byte_valid)
      begin
         case (fstate_reg) // see R21
            ST_ADDR_HI:
            begin
               addr_reg[15:8] <= bus.byte_data;
               fstate_reg     <= ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
               addr_reg[7:0] <= bus.byte_data;
               fstate_reg    <= ST_CTRL;
            end
            ST_CTRL:
            begin
               ctrl_reg   <= bus.byte_data; // see R27
               fstate_reg <= ST_DATA;
            end
            ST_DATA:
               addr_reg <= addr_reg + 16'h1; // see R22
            default:
               fstate_reg <= ST_ADDR_HI;
         endcase
      end
   end

   wire [2:0] sock   = ctrl_reg[7:CTL_SOCK_LSB];
   wire       do_wr  = bus.byte_valid && fstate_reg == ST_DATA && ctrl_reg[CTL_WRITE_BIT];
   wire [7:0] ofs    = addr_reg[7:0];
   wire [7:0] wdat   = bus.byte_data;

   // Read mux, big-endian pairs
   always_comb
   begin
      logic [15:0] w;
      w = 16'h0;
      rd_byte = 8'h00;
      case ({ofs[7:1], 1'b0}) // see R26
         OFS_TX_FREE:    w = tx_size[sock] - (tx_produce_reg[sock] - tx_consume_reg[sock]); // see R3
         OFS_TX_CONSUME: w = tx_consume_reg[sock];
         OFS_TX_PRODUCE: w = tx_produce_reg[sock];
         OFS_RX_SIZE:    w = rx_produce_reg[sock] - rx_consume_reg[sock]; // see R8
         OFS_RX_CONSUME: w = rx_consume_reg[sock];
         OFS_RX_PRODUCE: w = rx_produce_reg[sock];
         default:        w = 16'h0;
      endcase
      if (ofs >= OFS_TX_FREE && ofs < OFS_EVENT_MASK)
         rd_byte = ofs[0] ? w[7:0] : w[15:8];
      else if (ofs == OFS_EVENT_MASK)
         rd_byte = {EVENT_MASK_RESET[7:5], event_mask_reg[sock]}; // see R11
      else if (ofs == OFS_IP_FRAGMENT)
         rd_byte = ip_frag_reg[sock][15:8];
      else if (ofs == OFS_IP_FRAGMENT + 8'h1)
         rd_byte = ip_frag_reg[sock][7:0];
      else if (ofs == OFS_KEEPALIVE)
         rd_byte = keepalive_reg[sock];
      else if (ofs == OFS_TX_KBYTES)
         rd_byte = {3'h0, tx_kbytes_reg[sock]};
   end

   // Host-written configuration registers
   always_ff @(posedge clk_in)
   begin
      for (int s = 0; s < NUM_SOCKETS; s++)
      begin
         if (live_n)
         begin
            tx_kbytes_reg[s]  <= TX_KBYTES_RESET; // see R25
            event_mask_reg[s] <= EVENT_MASK_BITS; // see R11
            ip_frag_reg[s]    <= IP_FRAGMENT_RESET; // see R13
            keepalive_reg[s]  <= KEEPALIVE_RESET; // see R14
         end
         else if (do_wr && sock == 3'(s))
         begin
            if (ofs == OFS_TX_KBYTES && wdat <= 8'(TX_KBYTES_MAX))
               tx_kbytes_reg[s] <= wdat[4:0]; // see R25
            if (ofs == OFS_EVENT_MASK)
               event_mask_reg[s] <= wdat[4:0];
            if (ofs == OFS_IP_FRAGMENT)
               ip_frag_reg[s][15:8] <= wdat;
            if (ofs == OFS_IP_FRAGMENT + 8'h1)
               ip_frag_reg[s][7:0] <= wdat;
            if (ofs == OFS_KEEPALIVE)
               keepalive_reg[s] <= wdat;
         end
      end
   end

   // Pointers: host owns produce (tx) and consume (rx); device owns the rest
   always_ff @(posedge clk_in)
   begin
      for (int s = 0; s < NUM_SOCKETS; s++)
      begin
         // Any size change moves every later base, so all sockets restart their pointers
         if (live_n || socket_init_in[s] || (do_wr && ofs == OFS_TX_KBYTES)) // see R1
         begin
            tx_consume_reg[s] <= tx_base[s]; // see R5
            tx_produce_reg[s] <= tx_base[s];
            rx_consume_reg[s] <= 16'h0;
            rx_produce_reg[s] <= 16'h0; // see R10
         end
         else
         begin
            if (send_cmd_in[s])
               tx_consume_reg[s] <= tx_produce_reg[s]; // see R6
            if (rx_load_in[s])
               rx_produce_reg[s] <= rx_produce_reg[s] + rx_load_len_in; // see R10
            if (do_wr && sock == 3'(s) && ofs == OFS_TX_PRODUCE)
               tx_produce_reg[s][15:8] <= wdat;
            if (do_wr && sock == 3'(s) && ofs == OFS_TX_PRODUCE + 8'h1)
               tx_produce_reg[s][7:0] <= wdat;
            if (do_wr && sock == 3'(s) && ofs == OFS_RX_CONSUME)
               rx_consume_reg[s][15:8] <= wdat;
            if (do_wr && sock == 3'(s) && ofs == OFS_RX_CONSUME + 8'h1)
               rx_consume_reg[s][7:0] <= wdat;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (live_n)
      begin
         tx_send_out     <= 8'h00;
         tx_send_len_out <= 16'h0;
      end
      else
      begin
         tx_send_out     <= send_cmd_in;
         tx_send_len_out <= 16'h0;
         for (int s = 0; s < NUM_SOCKETS; s++)
            if (send_cmd_in[s])
               tx_send_len_out <= tx_produce_reg[s] - tx_consume_reg[s]; // see R6
      end
   end

   // Keep-alive timers
   always_ff @(posedge clk_in)
   begin
      for (int s = 0; s < NUM_SOCKETS; s++)
      begin
         if (live_n)
         begin
            ka_timer_reg[s]       <= 40'h0;
            ka_miss_reg[s]        <= 4'h0;
            keepalive_send_out[s] <= 1'b0;
         end
         else
         begin
            keepalive_send_out[s] <= 1'b0;
            if (keepalive_ack_in[s] || send_cmd_in[s] || rx_load_in[s])
               ka_miss_reg[s] <= 4'h0;
            if (keepalive_reg[s] == 8'h00 || !tcp_mode_in[s] ||
                socket_state_in[8*s +: 8] != STATE_ESTABLISHED || send_cmd_in[s] || rx_load_in[s])
            begin
               ka_timer_reg[s] <= 40'h0;
               if (keepalive_reg[s] == 8'h00 && keepalive_cmd_in[s])
                  keepalive_send_out[s] <= 1'b1; // see R17
            end
            // Forty bits hold 255 units of the full-rate count without wrapping
            else if (ka_timer_reg[s] >= 40'(KA_UNIT_CYCLES) * 40'(keepalive_reg[s]) - 40'h1)
            begin
               ka_timer_reg[s]       <= 40'h0;
               keepalive_send_out[s] <= 1'b1; // see R14 see R15
               if (!keepalive_ack_in[s] && ka_miss_reg[s] != 4'(KEEPALIVE_RETRIES))
                  ka_miss_reg[s] <= ka_miss_reg[s] + 4'h1;
            end
            else
               ka_timer_reg[s] <= ka_timer_reg[s] + 40'h1;
         end
      end
   end

   // Event flags; set wins over clear
   always_ff @(posedge clk_in)
   begin
      for (int s = 0; s < NUM_SOCKETS; s++)
      begin
         if (live_n)
            event_flags_reg[s] <= 5'h00;
         else
         begin
            // An event in the same cycle as an init clear still lands
            event_flags_reg[s] <= (socket_init_in[s] ? 5'h00 : event_flags_reg[s]) | event_in[5*s +: 5]; // see R24
            if (ka_miss_reg[s] == 4'(KEEPALIVE_RETRIES))
               event_flags_reg[s][EV_TIMEOUT] <= 1'b1; // see R16
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      logic any;
      any = 1'b0;
      for (int s = 0; s < NUM_SOCKETS; s++)
         if (socket_irq_mask_global_in[s] && |(event_flags_reg[s] & event_mask_reg[s]))
            any = 1'b1; // see R12
      if (live_n)
         irq_out_n <= 1'b1;
      else
         irq_out_n <= !any;
   end

   always_ff @(posedge clk_in)
   begin
      for (int s = 0; s < NUM_SOCKETS; s++)
         if (live_n)
            ip_fragment_out[16*s +: 16] <= IP_FRAGMENT_RESET;
         else
            ip_fragment_out[16*s +: 16] <= ip_frag_reg[s]; // see R13
   end

   // Output pin driven in the data phase of a read frame and for one clock at the start of the frame that follows it
   always_ff @(posedge clk_in)
   begin
      if (live_n)
      begin
         serial_out          <= 1'b0;
         serial_out_oe_n_out <= 1'b1;
      end
      else
      begin
         serial_out          <= tx_bit;
         serial_out_oe_n_out <= !(bus.frame_active && fstate_reg == ST_DATA && !ctrl_reg[CTL_WRITE_BIT]);
      end
   end

   AST_IRQ_MASKED: assert property (@(posedge clk_in) disable iff (live_n)
      (socket_irq_mask_global_in == 8'h00) |=> irq_out_n) // see R12
      else $error("irq asserted with all sockets masked");
   AST_KA_MANUAL: assert property (@(posedge clk_in) disable iff (live_n)
      (keepalive_cmd_in[0] && keepalive_reg[0] != 8'h00 && ka_timer_reg[0] == 40'h0 && tcp_mode_in[0] == 1'b0)
      |=> !keepalive_send_out[0]) // see R17
      else $error("manual keep-alive honoured with nonzero interval");
   AST_READY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !ext_ok_reg |=> ##1 !device_ready_out) // see R23
      else $error("ready while external reset active");
   AST_SEND_PULSE: assert property (@(posedge clk_in) disable iff (live_n) // see R6
      send_cmd_in[0] |=> tx_send_out[0])
      else $error("send command not passed on");
   AST_OE_WRITE: assert property (@(posedge clk_in) disable iff (live_n) // see R22
      (fstate_reg == ST_DATA && ctrl_reg[CTL_WRITE_BIT]) |=> serial_out_oe_n_out)
      else $error("output driven during a write frame");
   AST_KA_TIMEOUT: assert property (@(posedge clk_in) disable iff (live_n) // see R16
      (ka_miss_reg[0] == 4'(KEEPALIVE_RETRIES)) |=> event_flags_reg[0][EV_TIMEOUT])
      else $error("timeout flag missing after retries");
   cover property (@(posedge clk_in) disable iff (live_n) do_wr);
   cover property (@(posedge clk_in) disable iff (live_n) !irq_out_n);
   cover property (@(posedge clk_in) disable iff (live_n) |keepalive_send_out);
   cover property (@(posedge clk_in) disable iff (live_n) fall_pulse && !serial_out_oe_n_out);
endmodule // sock_regs

// ### dv/spi_host_model.sv
// Host master for the serial port, mode 0, paced by the bench clock.
// Assumes 16 clk_in cycles per half link period (160 ns link clock).
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic clk_in,
   input  wire logic miso_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out
);
   logic [7:0] dat [4];
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
      begin
         mosi_out <= b[i];
         wait_clk(16);
         sclk_out <= 1'b1;
         r[i] = miso_in;
         wait_clk(16);
         sclk_out <= 1'b0;
      end
   endtask
   task automatic frame(input logic [15:0] a, input logic [7:0] c, input int n);
      logic [7:0] r;
      cs_n_out <= 1'b0;
      wait_clk(4);
      put_byte(a[15:8], r);
      wait_clk(20);
      put_byte(a[7:0], r);
      wait_clk(20);
      put_byte(c, r);
      wait_clk(24);
      for (int k = 0; k < n; k++)
      begin
         put_byte(dat[k], r);
         dat[k] = r;
         wait_clk(20);
      end
      cs_n_out <= 1'b1;
      mosi_out <= ~mosi_out;
      // Gap covers the same-register processing time after writes
      wait_clk(200);
   endtask
endmodule // spi_host_model

// ### dv/tb_sock_regs.sv
// Self-checking bench for the socket register bank.
// Assumes the host model drives the link pins; short reset and unit counts.
`timescale 1ns/1ps
module tb_sock_regs;
   import sockbuf_pkg::*;
   logic         clk_in = 1'b0;
   logic         rst_n_in = 1'b0;
   logic         ext_n = 1'b0;
   logic [7:0]   glb = 8'h00;
   logic [7:0]   init_c = 8'h00;
   logic [7:0]   send_c = 8'h00;
   logic [7:0]   zero8 = 8'h00;
   logic [39:0]  ev = '0;
   logic         sclk, cs_n, mosi, miso, so, oe_n, irq_n, rdy;
   logic [7:0]   ka_out, snd;
   logic [15:0]  slen;
   logic [127:0] ipf;
   int           n_errors = 0;
   int           num_checks = 0;
   always #2.5 clk_in = ~clk_in;
   assign miso = oe_n ? 1'bz : so;
   spi_host_model u_spi_host_model (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
      .cs_n_out(cs_n), .mosi_out(mosi));
   sock_regs #(.RESET_CYCLES(20), .KA_UNIT_CYCLES(50)) u_sock_regs (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .ext_reset_n_in(ext_n), .sclk_in(sclk),
      .chip_select_n_in(cs_n), .serial_in(mosi), .socket_irq_mask_global_in(glb),
      .socket_init_in(init_c), .send_cmd_in(send_c), .keepalive_cmd_in(zero8),
      .keepalive_ack_in(zero8), .tcp_mode_in(zero8), .socket_state_in(64'h0),
      .rx_load_in(zero8), .rx_load_len_in(16'h0000), .event_in(ev),
      .serial_out(so), .serial_out_oe_n_out(oe_n), .irq_out_n(irq_n),
      .keepalive_send_out(ka_out), .tx_send_out(snd), .tx_send_len_out(slen),
      .ip_fragment_out(ipf), .device_ready_out(rdy));
   task automatic wrap_up();
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic t_reset_values();
      u_spi_host_model.frame({8'h00, OFS_EVENT_MASK}, 8'h00, 4);
      chk(u_spi_host_model.dat[0], 8'hff);
      chk(u_spi_host_model.dat[1], 8'h40);
      chk(u_spi_host_model.dat[2], 8'h00);
      chk(u_spi_host_model.dat[3], 8'h00);
      chk(ipf[15:8], IP_FRAGMENT_RESET[15:8]);
   endtask
   task automatic t_write_regs();
      u_spi_host_model.dat[0] = 8'h00;
      u_spi_host_model.dat[1] = 8'h12;
      u_spi_host_model.dat[2] = 8'h34;
      u_spi_host_model.dat[3] = 8'h05;
      u_spi_host_model.frame({8'h00, OFS_EVENT_MASK}, 8'h64, 4);
      u_spi_host_model.frame({8'h00, OFS_EVENT_MASK}, 8'h60, 4);
      chk(u_spi_host_model.dat[0], 8'he0);
      chk(u_spi_host_model.dat[2], 8'h34);
      chk(u_spi_host_model.dat[3], 8'h05);
      chk(ipf[63:56], 8'h12);
   endtask
   task automatic t_send();
      @(posedge clk_in) init_c <= 8'h01;
      @(posedge clk_in) init_c <= 8'h00;
      u_spi_host_model.frame({8'h00, OFS_TX_FREE}, 8'h00, 4);
      chk(u_spi_host_model.dat[0], 8'h08);
      chk(u_spi_host_model.dat[3], 8'h00);
      u_spi_host_model.dat[0] = 8'h01;
      u_spi_host_model.dat[1] = 8'h00;
      u_spi_host_model.frame({8'h00, OFS_TX_PRODUCE}, 8'h04, 2);
      @(posedge clk_in) send_c <= 8'h01;
      @(posedge clk_in) send_c <= 8'h00;
      for (int i = 0; i < 100 && snd[0] !== 1'b1; i++) @(negedge clk_in);
      if (snd[0] !== 1'b1)
      begin
         n_errors++;
         wrap_up();
      end
      chk(slen[15:8], 8'h01);
      u_spi_host_model.frame({8'h00, OFS_TX_CONSUME}, 8'h00, 2);
      chk(u_spi_host_model.dat[0], 8'h01);
      u_spi_host_model.dat[0] = 8'h00;
      u_spi_host_model.dat[1] = 8'h00;
      u_spi_host_model.frame({8'h00, OFS_RX_CONSUME}, 8'h04, 2);
      u_spi_host_model.frame({8'h00, OFS_RX_SIZE}, 8'h00, 2);
      chk(u_spi_host_model.dat[0], 8'h00);
      chk(u_spi_host_model.dat[1], 8'h00);
   endtask
   task automatic t_irq();
      @(posedge clk_in) ev <= 40'h4;
      @(posedge clk_in) ev <= '0;
      repeat (10) @(negedge clk_in);
      chk({7'h0, irq_n}, 8'h01);
      @(posedge clk_in) glb <= 8'h01;
      repeat (10) @(negedge clk_in);
      chk({7'h0, irq_n}, 8'h00);
   endtask
   initial
   begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      ext_n <= 1'b1;
      for (int i = 0; i < 200 && rdy !== 1'b1; i++) @(negedge clk_in);
      chk({7'h0, rdy}, 8'h01);
      t_reset_values();
      t_write_regs();
      t_send();
      t_irq();
      wrap_up();
   end
endmodule // tb_sock_regs
